// file: rtl/keylock_pkg.sv
// Constants, key codes, display frame codes and state types for the keypad lock.
// Assumes a single 200 MHz clock domain and keypad codes delivered one per cycle.
package keylock_pkg;
    localparam int CLK_PERIOD_NS = 5;
    localparam int SECOND_NS = 1000000000;
    localparam int TICK_CYCLES = SECOND_NS / CLK_PERIOD_NS;
    localparam int TICK_W = 28;

    // Times in seconds, counted on the one-second tick; then keyword length and fail limit
    localparam logic [7:0] IDLE_TIMEOUT_S = 8'hFF;
    localparam logic [7:0] WARN_S = 8'h05;
    localparam logic [7:0] LOCK_MSG_S = 8'hF0;
    localparam logic [13:0] LOCKOUT_S = 14'h3840;
    localparam int KW_DIGITS = 4;
    localparam logic [2:0] FAILS_TO_LOCK = 3'h4;

    // Key codes: 0..9 are digits
    localparam logic [3:0] KEY_DIGIT_MAX = 4'h9;
    localparam logic [3:0] KEY_CONFIRM = 4'hA;
    localparam logic [3:0] KEY_ABORT = 4'hB;

    // Reset values
    localparam logic [15:0] KEYWORD_RST = 16'h0000;
    localparam logic [13:0] LOCK_RST = 14'h0000;
    localparam logic [2:0] FAIL_RST = 3'h0;
    localparam logic [2:0] STAR_RST = 3'h0;

    // Error status bit driven by this block
    localparam int ERR_KEYPAD_BIT = 5;

    typedef enum logic [3:0]
    {
        FRAME_STANDARD = 4'h0,
        FRAME_MENU = 4'h1,
        FRAME_ASK_KEYWORD = 4'h2,
        FRAME_WARN_FIRST = 4'h3,
        FRAME_WARN_THIRD = 4'h4,
        FRAME_WARN_FOURTH = 4'h5,
        FRAME_LOCKED = 4'h6,
        FRAME_SET_KEYWORD = 4'h7
    } frame_t;

    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b000,
        ST_ASK = 3'b001,
        ST_WARN = 3'b010,
        ST_MENU = 3'b011,
        ST_SET = 3'b100,
        ST_LOCKMSG = 3'b101
    } state_t;
endpackage

// file: rtl/sec_tick.sv
// One-second tick generator dividing the system clock.
// Assumes the clock runs continuously at the rate set by the parameter.
module sec_tick #(
    parameter int TICK_CYCLES = keylock_pkg::TICK_CYCLES
)
(
    input wire logic ref_clk, // System clock
    input wire logic arst_n, // Asynchronous reset, active low
    output logic tick // One-cycle pulse each second
);
    logic [keylock_pkg::TICK_W-1:0] count;

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            count <= '0;
            tick <= 1'b0;
        end
        else if (count == keylock_pkg::TICK_W'(TICK_CYCLES - 1))
        begin
            count <= '0;
            tick <= 1'b1;
        end
        else
        begin
            count <= count + 1'b1;
            tick <= 1'b0;
        end
    end
endmodule

// file: rtl/sec_timer.sv
// Seconds down-counter with reload; pulses once when the loaded time has elapsed.
// Assumes a one-cycle tick each second; a load overrides a tick in the same cycle.
module sec_timer
(
    input wire logic ref_clk, // System clock
    input wire logic arst_n, // Asynchronous reset, active low
    input wire logic tick, // One-second tick
    input wire logic load, // Restart with loadVal
    input wire logic stop, // Halt without expiring
    input wire logic [7:0] loadVal, // Seconds to run
    output logic expired // One-cycle pulse at time-out
);
    logic [7:0] remain;
    logic running;

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            remain <= 8'h00;
            running <= 1'b0;
            expired <= 1'b0;
        end
        else
        begin
            expired <= 1'b0;
            if (load)
            begin
                remain <= loadVal;
                running <= 1'b1;
            end
            else if (stop)
                running <= 1'b0;
            else if (running && tick)
            begin
                if (remain <= 8'h01)
                begin
                    running <= 1'b0;
                    expired <= 1'b1;
                    remain <= 8'h00;
                end
                else
                    remain <= remain - 8'h01;
            end
        end
    end
endmodule

// file: rtl/keypad_keyword_lock.sv
// Keyword protection for the front-panel keypad menu, with wrong-entry lockout.
// Assumes keypad codes as one-cycle strobes and a retained store that hands back
// keyword and remaining lockout time after power-up and saves what is output.
// Function
// - With a keyword stored, ask for it on every main-menu selection.
// - Correct keyword opens the menu; protection stays off while it is open.
// - Re-arm protection on abort key or after 255 seconds without keys; abort during new-keyword entry (ST_SET) only returns to the open menu.
// - After factory delivery no keyword is stored; access is unprotected.
// - New keyword is four decimal digits, accepted only on confirm key.
// - Entering 0000 as new keyword erases it and disables protection.
// - A new keyword acts only from the next main-menu selection.
// - Show a star per digit and an arrow after the fourth.
// - Wrong keyword shows a warning 5 seconds; distinct texts by count.
// - Fourth failure locks keypad four hours; next attempt shows lockout.
// - Remaining lockout time survives a power cycle.
// - Lockout display returns to standard after four minutes or abort.
// - Remote factory default clears the keyword on the remote variant.
// - Error status bit five is one while the keypad is locked, following the lock one cycle later.
module keypad_keyword_lock #(
    parameter int TICK_CYCLES = keylock_pkg::TICK_CYCLES
)
(
    input wire logic ref_clk, // 200 MHz system clock
    input wire logic arst_n, // Asynchronous reset, active low
    input wire logic keyValid, // Key press strobe
    input wire logic [3:0] keyCode, // Digit 0..9, confirm_key or abort_key
    input wire logic menuSelect, // Operator picked a main-menu item
    input wire logic menuExit, // Menu system closed the open menu
    input wire logic setKeywordReq, // Keyword entry item chosen in open menu
    input wire logic factoryDefault, // Remote factory-default command strobe
    input wire logic remoteVariant, // High on the remote-capable variant
    input wire logic nvValid, // Retained values below are valid
    input wire logic [15:0] nvKeyword, // Retained keyword, BCD
    input wire logic nvKeywordSet, // Retained keyword present
    input wire logic [13:0] nvLockRemain, // Retained lockout seconds
    output logic menuOpen, // Selected menu is open
    output logic [3:0] frame, // Display frame code
    output logic [2:0] stars, // Masking stars shown
    output logic arrow, // Arrow marker shown
    output logic [7:0] errorByte, // Error status byte contribution
    output logic [15:0] keyword, // Stored keyword, to retained store
    output logic keywordSet, // Keyword present, to retained store
    output logic [13:0] lockRemain // Lockout seconds left, to retained store
);
    keylock_pkg::state_t state;
    logic tick;
    logic [2:0] failCnt;
    logic [2:0] digitCnt;
    logic [3:0] entry [keylock_pkg::KW_DIGITS];
    logic [15:0] entryWord;
    logic restored;
    logic idleLoad;
    logic idleExpired;
    logic msgLoad;
    logic msgStop;
    logic [7:0] msgTime;
    logic msgExpired;
    logic isDigit;
    logic isConfirm;
    logic isAbort;
    logic locked;
    logic entryFull;
    logic kwMatch;

    sec_tick #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_tick (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .tick(tick)
    );

    sec_timer u_idle (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .tick(tick),
        .load(idleLoad),
        .stop(state == keylock_pkg::ST_IDLE),
        .loadVal(keylock_pkg::IDLE_TIMEOUT_S),
        .expired(idleExpired)
    );

    sec_timer u_msg (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .tick(tick),
        .load(msgLoad),
        .stop(msgStop),
        .loadVal(msgTime),
        .expired(msgExpired)
    );

    assign isDigit = keyValid && (keyCode <= keylock_pkg::KEY_DIGIT_MAX);
    assign isConfirm = keyValid && (keyCode == keylock_pkg::KEY_CONFIRM);
    assign isAbort = keyValid && (keyCode == keylock_pkg::KEY_ABORT);
    assign locked = (lockRemain != keylock_pkg::LOCK_RST);
    assign entryFull = (digitCnt == 3'(keylock_pkg::KW_DIGITS));
    assign entryWord = {entry[0], entry[1], entry[2], entry[3]};
    assign kwMatch = entryFull && (entryWord == keyword);

    // Any key press inside a session restarts the inactivity timer
    assign idleLoad = (keyValid && state != keylock_pkg::ST_IDLE)
        || (state == keylock_pkg::ST_IDLE && menuSelect && !locked);

    // Warning and lockout messages share one timer, never both at once
    always_comb
    begin
        msgLoad = 1'b0;
        msgStop = 1'b0;
        msgTime = keylock_pkg::WARN_S;
        if (state == keylock_pkg::ST_ASK && isConfirm && !kwMatch)
            msgLoad = 1'b1;
        else if (state == keylock_pkg::ST_IDLE && menuSelect && locked)
        begin
            msgLoad = 1'b1;
            msgTime = keylock_pkg::LOCK_MSG_S;
        end
        else if (state == keylock_pkg::ST_LOCKMSG && isAbort)
            msgStop = 1'b1;
    end

    // Digits land in the slot the count points at; extras beyond four drop
    generate
        for (genvar i = 0; i < keylock_pkg::KW_DIGITS; i++)
        begin : g_entry
            always_ff @(posedge ref_clk or negedge arst_n)
            begin
                if (!arst_n)
                    entry[i] <= 4'h0;
                else if (isDigit && digitCnt == 3'(i))
                    entry[i] <= keyCode;
            end
        end
    endgenerate

    // Digit count and masking display
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            digitCnt <= keylock_pkg::STAR_RST;
            stars <= keylock_pkg::STAR_RST;
            arrow <= 1'b0;
        end
        else if (state == keylock_pkg::ST_ASK || state == keylock_pkg::ST_SET)
        begin
            if (isConfirm || isAbort)
            begin
                digitCnt <= keylock_pkg::STAR_RST;
                stars <= keylock_pkg::STAR_RST;
                arrow <= 1'b0;
            end
            else if (isDigit && !entryFull)
            begin
                digitCnt <= digitCnt + 3'h1;
                stars <= digitCnt + 3'h1;
                arrow <= (digitCnt == 3'(keylock_pkg::KW_DIGITS - 1));
            end
        end
        else
        begin
            digitCnt <= keylock_pkg::STAR_RST;
            stars <= keylock_pkg::STAR_RST;
            arrow <= 1'b0;
        end
    end

    // Session state machine
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            state <= keylock_pkg::ST_IDLE;
        else
        begin
            case (state)
                keylock_pkg::ST_IDLE:
                begin
                    if (menuSelect && locked)
                        state <= keylock_pkg::ST_LOCKMSG;
                    else if (menuSelect && keywordSet)
                        state <= keylock_pkg::ST_ASK;
                    else if (menuSelect)
                        state <= keylock_pkg::ST_MENU;
                end
                keylock_pkg::ST_ASK:
                begin
                    if (isAbort || idleExpired)
                        state <= keylock_pkg::ST_IDLE;
                    else if (isConfirm && kwMatch)
                        state <= keylock_pkg::ST_MENU;
                    else if (isConfirm)
                        state <= keylock_pkg::ST_WARN;
                end
                keylock_pkg::ST_WARN:
                begin
                    if (msgExpired)
                        state <= keylock_pkg::ST_IDLE;
                end
                keylock_pkg::ST_MENU:
                begin
                    if (isAbort || menuExit || idleExpired)
                        state <= keylock_pkg::ST_IDLE;
                    else if (setKeywordReq)
                        state <= keylock_pkg::ST_SET;
                end
                keylock_pkg::ST_SET:
                begin
                    if (idleExpired)
                        state <= keylock_pkg::ST_IDLE;
                    else if (isAbort || (isConfirm && entryFull))
                        state <= keylock_pkg::ST_MENU;
                end
                keylock_pkg::ST_LOCKMSG:
                begin
                    if (msgExpired || isAbort)
                        state <= keylock_pkg::ST_IDLE;
                end
                default:
                    state <= keylock_pkg::ST_IDLE;
            endcase
        end
    end

    // Keyword store; comparison only happens at a selection, so a new one
    // waits for the next menu session on its own
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            keyword <= keylock_pkg::KEYWORD_RST;
            keywordSet <= 1'b0;
            restored <= 1'b0;
        end
        else if (!restored)
        begin
            // Retained copy is taken after reset release, never under reset
            if (nvValid)
            begin
                keyword <= nvKeyword;
                keywordSet <= nvKeywordSet;
                restored <= 1'b1;
            end
        end
        else if (factoryDefault && remoteVariant)
        begin
            keyword <= keylock_pkg::KEYWORD_RST;
            keywordSet <= 1'b0;
        end
        else if (state == keylock_pkg::ST_SET && isConfirm && entryFull)
        begin
            if (entryWord == keylock_pkg::KEYWORD_RST)
            begin
                keyword <= keylock_pkg::KEYWORD_RST;
                keywordSet <= 1'b0;
            end
            else
            begin
                keyword <= entryWord;
                keywordSet <= 1'b1;
            end
        end
    end

    // Wrong-entry counter and lockout time
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            failCnt <= keylock_pkg::FAIL_RST;
            lockRemain <= keylock_pkg::LOCK_RST;
        end
        else if (!restored)
        begin
            if (nvValid)
                lockRemain <= nvLockRemain;
        end
        else if (state == keylock_pkg::ST_ASK && isConfirm)
        begin
            if (kwMatch)
                failCnt <= keylock_pkg::FAIL_RST;
            else if (failCnt == keylock_pkg::FAILS_TO_LOCK - 3'h1)
            begin
                failCnt <= keylock_pkg::FAILS_TO_LOCK;
                lockRemain <= keylock_pkg::LOCKOUT_S;
            end
            else
                failCnt <= failCnt + 3'h1;
        end
        else if (locked && tick)
        begin
            lockRemain <= lockRemain - 14'h0001;
            if (lockRemain == 14'h0001)
                failCnt <= keylock_pkg::FAIL_RST;
        end
    end

    // Display frame and menu flag; the other functions never depend on these
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            frame <= keylock_pkg::FRAME_STANDARD;
            menuOpen <= 1'b0;
            errorByte <= 8'h00;
        end
        else
        begin
            menuOpen <= (state == keylock_pkg::ST_MENU || state == keylock_pkg::ST_SET);
            errorByte <= 8'h00;
            errorByte[keylock_pkg::ERR_KEYPAD_BIT] <= locked;
            case (state)
                keylock_pkg::ST_IDLE:
                    frame <= keylock_pkg::FRAME_STANDARD;
                keylock_pkg::ST_ASK:
                    frame <= keylock_pkg::FRAME_ASK_KEYWORD;
                keylock_pkg::ST_WARN:
                begin
                    if (failCnt == keylock_pkg::FAILS_TO_LOCK)
                        frame <= keylock_pkg::FRAME_WARN_FOURTH;
                    else if (failCnt == 3'h3)
                        frame <= keylock_pkg::FRAME_WARN_THIRD;
                    else
                        frame <= keylock_pkg::FRAME_WARN_FIRST;
                end
                keylock_pkg::ST_MENU:
                    frame <= keylock_pkg::FRAME_MENU;
                keylock_pkg::ST_SET:
                    frame <= keylock_pkg::FRAME_SET_KEYWORD;
                keylock_pkg::ST_LOCKMSG:
                    frame <= keylock_pkg::FRAME_LOCKED;
                default:
                    frame <= keylock_pkg::FRAME_STANDARD;
            endcase
        end
    end
endmodule

// file: sim/keypad_panel_model.sv
// Keypad side of the panel: presses keys as one-cycle strobes.
// Assumes the lock samples keys on the rising clock edge.
module keypad_panel_model
(
    input wire logic ref_clk, // System clock
    output logic keyValid, // Key strobe
    output logic [3:0] keyCode // Key code
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        keyValid = 1'b0;
        keyCode = 4'h5;
    end

    task automatic press(input logic [3:0] c);
        @(posedge ref_clk);
        keyValid <= 1'b1;
        keyCode <= c;
        @(posedge ref_clk);
        keyValid <= 1'b0;
        keyCode <= ~c; // Stale code never left on the lines
    endtask

    // Digits go out most significant first
    task automatic typeDigits(input logic [15:0] k, input int n);
        for (int i = 0; i < n; i++)
            press(k[15 - 4 * i -: 4]);
    endtask
endmodule

// file: sim/keylock_monitor.sv
// Concurrent checks on the ports of the keypad lock.
// Assumes one clock domain and the frame codes of keylock_pkg.
module keylock_monitor #(
    parameter int TICK_CYCLES = keylock_pkg::TICK_CYCLES
)
(
    input wire logic ref_clk, // Clock
    input wire logic arst_n, // Reset, active low
    input wire logic keyValid, // Key strobe
    input wire logic [3:0] keyCode, // Key code
    input wire logic menuSelect, // Menu pick
    input wire logic menuExit, // Menu closed
    input wire logic setKeywordReq, // Set entry
    input wire logic factoryDefault, // Remote default
    input wire logic remoteVariant, // Variant
    input wire logic nvValid, // Store valid
    input wire logic [15:0] nvKeyword, // Stored keyword
    input wire logic nvKeywordSet, // Stored flag
    input wire logic [13:0] nvLockRemain, // Stored lockout
    input wire logic menuOpen, // Menu open
    input wire logic [3:0] frame, // Frame code
    input wire logic [2:0] stars, // Stars
    input wire logic arrow, // Arrow
    input wire logic [7:0] errorByte, // Error byte
    input wire logic [15:0] keyword, // Keyword
    input wire logic keywordSet, // Keyword flag
    input wire logic [13:0] lockRemain // Lockout left
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    wire logic idleSel = menuSelect && frame == keylock_pkg::FRAME_STANDARD;
    wire logic locked = lockRemain != 14'h0000;
    wire logic entry = frame == keylock_pkg::FRAME_ASK_KEYWORD
        || frame == keylock_pkg::FRAME_SET_KEYWORD;

    chk_err_other: assert property (errorByte[7:6] == 2'h0 && errorByte[4:0] == 5'h00)
        else $error("unused error bits set");
    chk_err_lock_set: assert property (locked && $past(locked) |-> errorByte[5])
        else $error("bit five low while locked");
    chk_err_lock_clr: assert property (!locked && !$past(locked) |-> !errorByte[5])
        else $error("bit five high while unlocked");
    chk_lock_count: assert property ($past(locked) && lockRemain != $past(lockRemain)
        |-> lockRemain == $past(lockRemain) - 14'h0001) else $error("lockout jumped");
    chk_star_limit: assert property (stars <= 3'h4 && (!arrow || stars == 3'h4))
        else $error("star count wrong");
    chk_fourth_star: assert property (keyValid && keyCode <= keylock_pkg::KEY_DIGIT_MAX
        && stars == 3'h3 && entry |-> ##[1:2] (stars == 3'h4 && arrow))
        else $error("no arrow after fourth digit");
    chk_ask_select: assert property (idleSel && keywordSet && !locked
        |-> ##[2:3] frame == keylock_pkg::FRAME_ASK_KEYWORD) else $error("keyword not asked");
    chk_open_unprot: assert property (idleSel && !keywordSet && !locked
        |-> ##[2:3] (menuOpen && frame == keylock_pkg::FRAME_MENU)) else $error("menu not opened");
    chk_lock_msg: assert property (idleSel && locked
        |-> ##[2:3] (frame == keylock_pkg::FRAME_LOCKED && !menuOpen)) else $error("no lock frame");
    chk_abort_leave: assert property (keyValid && keyCode == keylock_pkg::KEY_ABORT
        && (frame == keylock_pkg::FRAME_MENU || frame == keylock_pkg::FRAME_LOCKED)
        |-> ##[2:3] (frame == keylock_pkg::FRAME_STANDARD && !menuOpen))
        else $error("abort not obeyed");
    chk_menu_exit: assert property (menuExit && frame == keylock_pkg::FRAME_MENU
        |-> ##[2:3] !menuOpen) else $error("menu stays open");
    chk_kw_format: assert property (keywordSet |-> keyword != 16'h0000
        && keyword[15:12] <= 4'h9 && keyword[11:8] <= 4'h9 && keyword[7:4] <= 4'h9
        && keyword[3:0] <= 4'h9) else $error("bad stored keyword");
endmodule

bind keypad_keyword_lock keylock_monitor #(.TICK_CYCLES(TICK_CYCLES)) i_keylock_monitor (
    .ref_clk(ref_clk), .arst_n(arst_n), .keyValid(keyValid), .keyCode(keyCode),
    .menuSelect(menuSelect), .menuExit(menuExit), .setKeywordReq(setKeywordReq),
    .factoryDefault(factoryDefault), .remoteVariant(remoteVariant), .nvValid(nvValid),
    .nvKeyword(nvKeyword), .nvKeywordSet(nvKeywordSet), .nvLockRemain(nvLockRemain),
    .menuOpen(menuOpen), .frame(frame), .stars(stars), .arrow(arrow), .errorByte(errorByte),
    .keyword(keyword), .keywordSet(keywordSet), .lockRemain(lockRemain));

// file: sim/keypad_keyword_lock_tb.sv
// Self-checking bench for the keypad lock; frame changes are scored from a queue.
// Assumes a four-cycle second so that all timers but the four-hour lockout finish in a short run.
module keypad_keyword_lock_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [3:0] ctl = 4'h0;
    logic remoteVariant = 1'b0;
    logic nvValid = 1'b0;
    logic nvKeywordSet = 1'b0;
    logic [15:0] nvKeyword = 16'h0000;
    logic [13:0] nvLockRemain = 14'h0000;
    logic keyValid, arrow, menuOpen, keywordSet;
    logic [3:0] keyCode, frame;
    logic [2:0] stars;
    logic [7:0] errorByte;
    logic [15:0] keyword, kw;
    logic [13:0] lockRemain;
    logic [3:0] expQ[$];
    logic [3:0] lastFrame = 4'h0;
    int mismatches = 0;
    int n_checks = 0;

    always #2.5 ref_clk = ~ref_clk;

    keypad_panel_model i_keypad_panel_model (.ref_clk(ref_clk), .keyValid(keyValid),
        .keyCode(keyCode));

    keypad_keyword_lock #(.TICK_CYCLES(4)) i_keypad_keyword_lock (.ref_clk(ref_clk),
        .arst_n(arst_n), .keyValid(keyValid), .keyCode(keyCode), .menuSelect(ctl[0]),
        .menuExit(ctl[1]), .setKeywordReq(ctl[2]), .factoryDefault(ctl[3]),
        .remoteVariant(remoteVariant), .nvValid(nvValid), .nvKeyword(nvKeyword),
        .nvKeywordSet(nvKeywordSet), .nvLockRemain(nvLockRemain), .menuOpen(menuOpen),
        .frame(frame), .stars(stars), .arrow(arrow), .errorByte(errorByte),
        .keyword(keyword), .keywordSet(keywordSet), .lockRemain(lockRemain));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic final_report;
        $display("checks=%0d mismatches=%0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Each frame change takes the oldest expected frame
    always @(posedge ref_clk)
        if (arst_n && frame !== lastFrame)
        begin
            lastFrame <= frame;
            check(16'(frame), expQ.size() > 0 ? 16'(expQ.pop_front()) : 16'hFFFF);
        end

    task automatic settle;
        repeat (3) @(posedge ref_clk);
        #1;
    endtask

    task automatic act(input int b, input logic [3:0] f);
        // A default pulse leaves the frame alone, so it queues nothing
        if (b != 3)
            expQ.push_back(f);
        @(posedge ref_clk);
        ctl[b] <= 1'b1;
        @(posedge ref_clk);
        ctl[b] <= 1'b0;
        settle;
    endtask

    task automatic key(input logic [3:0] c, input logic [3:0] f);
        expQ.push_back(f);
        i_keypad_panel_model.press(c);
        settle;
    endtask

    task automatic attempt(input logic [15:0] k, input int n, input logic [3:0] f);
        i_keypad_panel_model.typeDigits(k, n);
        key(keylock_pkg::KEY_CONFIRM, f);
    endtask

    task automatic waitStandard(input int limit);
        int n;
        n = 0;
        expQ.push_back(keylock_pkg::FRAME_STANDARD);
        while (frame !== keylock_pkg::FRAME_STANDARD && n < limit)
        begin
            @(posedge ref_clk);
            n++;
        end
        settle;
        check(16'(frame), 16'(keylock_pkg::FRAME_STANDARD));
    endtask

    task automatic wrong(input logic [3:0] w, input int n);
        act(0, keylock_pkg::FRAME_ASK_KEYWORD);
        attempt(kw ^ 16'h0001, n, w);
        waitStandard(40);
    endtask

    task automatic doReset(input logic s, input logic [13:0] l);
        arst_n <= 1'b0;
        nvValid <= 1'b0;
        repeat (12) @(posedge ref_clk);
        arst_n <= 1'b1;
        nvKeyword <= s ? kw : 16'h0000;
        nvKeywordSet <= s;
        nvLockRemain <= l;
        @(posedge ref_clk);
        nvValid <= 1'b1;
        settle;
    endtask

    initial
    begin
        void'($urandom(32'hBE48));
        kw = {4'h1 + 4'($urandom % 9), 4'($urandom % 10), 4'($urandom % 10), 4'($urandom % 10)};
        doReset(1'b0, 14'h0000);
        check(16'({keywordSet, errorByte}), 16'h0000);
        act(0, keylock_pkg::FRAME_MENU);
        act(2, keylock_pkg::FRAME_SET_KEYWORD);
        i_keypad_panel_model.typeDigits(kw, 3);
        i_keypad_panel_model.press(keylock_pkg::KEY_CONFIRM);
        settle;
        // Short confirm is not taken and starts the entry over
        check(16'({keywordSet, arrow, stars}), 16'h0000);
        i_keypad_panel_model.typeDigits(kw, 4);
        i_keypad_panel_model.press(4'h7);
        settle;
        check(16'({arrow, stars}), 16'h000C);
        key(keylock_pkg::KEY_CONFIRM, keylock_pkg::FRAME_MENU);
        check(keyword, kw);
        check(16'({keywordSet, menuOpen}), 16'h0003);
        act(1, keylock_pkg::FRAME_STANDARD);
        wrong(keylock_pkg::FRAME_WARN_FIRST, 4);
        act(0, keylock_pkg::FRAME_ASK_KEYWORD);
        attempt(kw, 4, keylock_pkg::FRAME_MENU);
        key(keylock_pkg::KEY_ABORT, keylock_pkg::FRAME_STANDARD);
        // Short entry counts as wrong; earlier failure must not carry over
        for (int i = 0; i < 4; i++)
            wrong(i < 2 ? keylock_pkg::FRAME_WARN_FIRST : i == 2 ? keylock_pkg::FRAME_WARN_THIRD
                : keylock_pkg::FRAME_WARN_FOURTH, i == 0 ? 3 : 4);
        check(16'(errorByte), 16'h0020);
        check(16'(lockRemain > keylock_pkg::LOCKOUT_S - 14'h0008), 16'h0001);
        act(0, keylock_pkg::FRAME_LOCKED);
        key(keylock_pkg::KEY_ABORT, keylock_pkg::FRAME_STANDARD);
        act(0, keylock_pkg::FRAME_LOCKED);
        waitStandard(1000);
        doReset(1'b1, 14'h0003);
        check(16'(errorByte), 16'h0020);
        repeat (20) @(posedge ref_clk);
        check(16'(errorByte), 16'h0000);
        wrong(keylock_pkg::FRAME_WARN_FIRST, 4);
        act(0, keylock_pkg::FRAME_ASK_KEYWORD);
        attempt(kw, 4, keylock_pkg::FRAME_MENU);
        waitStandard(1100);
        act(0, keylock_pkg::FRAME_ASK_KEYWORD);
        attempt(kw, 4, keylock_pkg::FRAME_MENU);
        act(2, keylock_pkg::FRAME_SET_KEYWORD);
        attempt(16'h0000, 4, keylock_pkg::FRAME_MENU);
        check(16'(keywordSet), 16'h0000);
        act(1, keylock_pkg::FRAME_STANDARD);
        act(0, keylock_pkg::FRAME_MENU);
        act(2, keylock_pkg::FRAME_SET_KEYWORD);
        attempt(kw, 4, keylock_pkg::FRAME_MENU);
        act(3, keylock_pkg::FRAME_MENU);
        check(16'(keywordSet), 16'h0001);
        @(posedge ref_clk);
        remoteVariant <= 1'b1;
        act(3, keylock_pkg::FRAME_MENU);
        check(16'(keywordSet), 16'h0000);
        act(1, keylock_pkg::FRAME_STANDARD);
        // Every expected frame must have been seen
        check(16'(expQ.size()), 16'h0000);
        final_report;
    end

    initial
    begin
        repeat (20000) @(posedge ref_clk);
        mismatches++;
        final_report;
    end
endmodule
